// ===== common/cpu_logic_params.svh
`ifndef CPU_LOGIC_PARAMS_SVH
`define CPU_LOGIC_PARAMS_SVH

// --------------------
// Operand widths and positions
// --------------------
`define BYTE_W 8
`define WORD_W 16
`define LONG_W 32
`define ADDR_W 32
`define BYTE_MSB 5'd7
`define WORD_MSB 5'd15
`define LONG_MSB 5'd31
`define BIT_IDX_W 3
`define TAS_BIT 3'd7

// --------------------
// Masks and reset values
// --------------------
`define BYTE_MASK 32'h0000_00ff
`define WORD_MASK 32'h0000_ffff
`define LONG_MASK 32'hffff_ffff
`define RESULT_RST 32'h0000_0000
`define BYTE_RST 8'h00

`endif

// ===== common/cpu_logic_pkg.sv
`default_nettype none

package cpu_logic_pkg;

    // --------------------
    // Operand size codes
    // --------------------
    typedef enum logic [1:0]
    {
        size_byte = 2'h0,
        size_word = 2'h1,
        size_long = 2'h2
    } size_type;

    // --------------------
    // Operations of this group
    // --------------------
    typedef enum logic [4:0]
    {
        zero_extend_op = 5'h00,
        sign_extend_op = 5'h01,
        test_and_set_op = 5'h02,
        and_op = 5'h03,
        or_op = 5'h04,
        xor_op = 5'h05,
        not_op = 5'h06,
        arith_shift_left_op = 5'h07,
        arith_shift_right_op = 5'h08,
        logic_shift_left_op = 5'h09,
        logic_shift_right_op = 5'h0a,
        rotate_left_op = 5'h0b,
        rotate_right_op = 5'h0c,
        rotate_carry_left_op = 5'h0d,
        rotate_carry_right_op = 5'h0e,
        bit_set_op = 5'h0f,
        bit_clear_op = 5'h10,
        bit_invert_op = 5'h11,
        bit_test_op = 5'h12,
        carry_and_bit_op = 5'h13,
        carry_and_inv_bit_op = 5'h14,
        carry_or_bit_op = 5'h15,
        carry_or_inv_bit_op = 5'h16
    } op_type;

    // --------------------
    // Shift unit modes
    // --------------------
    typedef enum logic [2:0]
    {
        sk_asl = 3'h0,
        sk_asr = 3'h1,
        sk_lsl = 3'h2,
        sk_lsr = 3'h3,
        sk_rol = 3'h4,
        sk_ror = 3'h5,
        sk_rcl = 3'h6,
        sk_rcr = 3'h7
    } shift_kind_type;

    // --------------------
    // Sequencer states
    // --------------------
    typedef enum logic [2:0]
    {
        st_idle = 3'b001,
        st_read = 3'b010,
        st_write = 3'b100
    } state_type;

endpackage : cpu_logic_pkg

`default_nettype wire

// ===== common/shift_if.sv
`timescale 1ns/100ps
`default_nettype none

interface shift_if;
    import cpu_logic_pkg::*;
    logic [31:0] data;
    size_type size;
    shift_kind_type kind;
    logic two;
    logic carry_in;
    logic [31:0] result;
    logic carry_out;

    modport unit (input data, size, kind, two, carry_in, output result, carry_out);
    modport user (output data, size, kind, two, carry_in, input result, carry_out);
endinterface : shift_if

`default_nettype wire

// ===== dv/cpu_logic_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module cpu_logic_asserts
    import cpu_logic_pkg::*;
#(
    parameter int unsigned ADDR_W = 32
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic ready,
    input wire op_type op,
    input wire size_type size,
    input wire logic [31:0] dst_data,
    input wire logic [31:0] src_data,
    input wire logic [31:0] imm_data,
    input wire logic use_imm,
    input wire logic [2:0] bit_imm,
    input wire logic bit_from_reg,
    input wire logic mem_operand,
    input wire logic carry_in,
    input wire logic done,
    input wire logic [31:0] result,
    input wire logic flag_c,
    input wire logic flag_c_we,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack
);
    logic go;
    logic mem_op;
    op_type last_op_q;

    assign go = start && ready;
    assign mem_op = op == test_and_set_op || (mem_operand && op >= bit_set_op);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            last_op_q <= zero_extend_op;
        end
        else if (go)
        begin
            last_op_q <= op;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_reg_go(op_type o);
        go && !mem_op && op == o && size == size_long;
    endsequence
    sequence s_tas_read;
        mem_req && !mem_we && mem_ack && last_op_q == test_and_set_op;
    endsequence

    a_and_result: assert property (s_reg_go(and_op) ##0 !use_imm |=>
        done && result == $past(dst_data & src_data)) else $error("and result wrong");
    a_xor_imm: assert property (s_reg_go(xor_op) ##0 use_imm |=>
        result == $past(dst_data ^ imm_data)) else $error("xor result wrong");
    a_not_result: assert property (go && op == not_op && size == size_byte |=>
        result == {$past(dst_data[31:8]), ~$past(dst_data[7:0])})
        else $error("not result wrong");
    a_zero_ext: assert property (s_reg_go(zero_extend_op) |=>
        result == {16'h0000, $past(dst_data[15:0])}) else $error("zero extend wrong");
    a_sign_ext: assert property (s_reg_go(sign_extend_op) |=>
        result == {{16{$past(dst_data[15])}}, $past(dst_data[15:0])})
        else $error("sign extend wrong");
    a_carry_and: assert property (go && !mem_op && op == carry_and_bit_op && !bit_from_reg
        |=> flag_c_we && flag_c == ($past(carry_in) && $past(dst_data[bit_imm])))
        else $error("carry and wrong");
    a_tas_write: assert property (s_tas_read |=>
        mem_req && mem_we && mem_wdata == ($past(mem_rdata) | 8'h80))
        else $error("set byte write wrong");
    a_req_holds: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_addr) && $stable(mem_we)) else $error("request dropped");
endmodule : cpu_logic_asserts

bind cpu_logic_shift_bit_datapath cpu_logic_asserts #(.ADDR_W(ADDR_W)) cpu_logic_asserts_inst
(
    .clk, .rst, .start, .ready, .op, .size, .dst_data, .src_data, .imm_data, .use_imm,
    .bit_imm, .bit_from_reg, .mem_operand, .carry_in, .done, .result, .flag_c, .flag_c_we,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack
);

`default_nettype wire

// ===== dv/cpu_logic_shift_bit_datapath_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
    $display("mismatch %0t got %h", $time, a); end end

module cpu_logic_shift_bit_datapath_tb_top;
    import cpu_logic_pkg::*;
    logic clk, rst, start, use_imm, shift_two, bit_from_reg, mem_operand, carry_in;
    logic ready, done, result_we, flag_n, flag_n_we, flag_z, flag_z_we, flag_c, flag_c_we;
    logic mem_req, mem_we, mem_ack;
    logic [1:0] lag;
    logic [2:0] bit_imm;
    logic [7:0] mem_wdata, mem_rdata;
    logic [31:0] dst_data, src_data, imm_data, bit_reg, mem_addr_in, result, mem_addr;
    op_type op;
    size_type size;
    int err_total, compares;
    logic [0:3][31:0] ext_exp = {32'h0000_8085, 32'hffff_8085, 32'h1234_0085, 32'h1234_ff85};
    logic [0:15][7:0] sh_exp = {8'h2c, 8'h58, 8'hcb, 8'he5, 8'h2c, 8'h58, 8'h4b, 8'h25,
        8'h2d, 8'h5a, 8'h4b, 8'ha5, 8'h2d, 8'h5b, 8'hcb, 8'h65};
    logic [0:15][7:0] bit_exp = {8'ha7, 8'ha5, 8'ha5, 8'ha1, 8'ha7, 8'ha1, 8'h01, 8'h00,
        8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};

    cpu_logic_shift_bit_datapath cpu_logic_shift_bit_datapath_inst
    (
        .clk, .rst, .start, .op, .size, .dst_data, .src_data, .imm_data, .use_imm, .shift_two,
        .bit_imm, .bit_from_reg, .bit_reg, .mem_operand, .mem_addr_in, .carry_in, .ready,
        .done, .result, .result_we, .flag_n, .flag_n_we, .flag_z, .flag_z_we, .flag_c,
        .flag_c_we, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack
    );
    mem_model mem_model_inst
    (
        .clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .lag, .mem_rdata, .mem_ack
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    // Start stands for one taking edge
    task automatic go();
        @(posedge clk);
        #1;
        start = 1'b1;
        @(posedge clk);
        #1;
        start = 1'b0;
        for (int n = 0; n < 20 && done !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        `CHK(done, 1'b1)
    endtask : go

    task automatic t_logic();
        dst_data = 32'hf0f0_a5a5;
        src_data = 32'h0ff0_3c3c;
        imm_data = 32'h1234_5678;
        size = size_long;
        op = and_op;
        go();
        `CHK(result, 32'h00f0_2424)
        size = size_word;
        go();
        `CHK(result, 32'hf0f0_2424)
        size = size_long;
        use_imm = 1'b1;
        op = or_op;
        go();
        `CHK(result, 32'hf2f4_f7fd)
        op = xor_op;
        go();
        `CHK(result, 32'he2c4_f3dd)
        size = size_byte;
        op = not_op;
        go();
        `CHK({result, flag_n, flag_z}, {32'hf0f0_a55a, 2'b00})
        `CHK({result_we, flag_n_we, flag_z_we, flag_c_we}, 4'he)
        $display("logic test end");
    endtask : t_logic

    task automatic t_ext();
        dst_data = 32'h1234_8085;
        for (int i = 0; i < 4; i++)
        begin
            op = op_type'(i % 2);
            size = i < 2 ? size_long : size_word;
            go();
            `CHK(result, ext_exp[i])
        end
        $display("extend test end");
    endtask : t_ext

    task automatic t_shift();
        dst_data = 32'h0000_0096;
        size = size_byte;
        for (int i = 0; i < 16; i++)
        begin
            op = op_type'(7 + i / 2);
            shift_two = i[0];
            carry_in = i > 11;
            go();
            `CHK(result, {24'h0, sh_exp[i]})
            `CHK(flag_n, sh_exp[i][7])
        end
        $display("shift test end");
    endtask : t_shift

    // Index 1 is zero, index 2 is one
    task automatic t_bit();
        dst_data = 32'h0000_00a5;
        bit_reg = 32'hffff_fff9;
        bit_imm = 3'h2;
        for (int i = 0; i < 16; i++)
        begin
            op = op_type'(15 + i / 2);
            bit_from_reg = !i[0];
            carry_in = i < 12;
            go();
            if (i < 6)
                `CHK(result, {24'h0, bit_exp[i]})
            else if (i < 8)
                `CHK(flag_z, bit_exp[i][0])
            else
                `CHK(flag_c, bit_exp[i][0])
        end
        $display("bit test end");
    endtask : t_bit

    task automatic t_mem();
        mem_operand = 1'b1;
        mem_addr_in = 32'h0000_0004;
        op = test_and_set_op;
        go();
        `CHK(flag_z, 1'b1)
        go();
        `CHK({flag_n, flag_z, mem_model_inst.mem[4]}, 10'h280)
        lag = 2'h2;
        op = bit_clear_op;
        bit_from_reg = 1'b0;
        bit_imm = 3'h7;
        go();
        `CHK(mem_model_inst.mem[4], 8'h00)
        op = bit_test_op;
        bit_imm = 3'h0;
        go();
        `CHK({flag_z, result_we}, 2'b10)
        $display("memory test end");
    endtask : t_mem

    initial
    begin
        err_total = 0;
        compares = 0;
        rst = 1'b1;
        {start, use_imm, shift_two, bit_from_reg, mem_operand, carry_in} = '0;
        {dst_data, src_data, imm_data, bit_reg, mem_addr_in} = '0;
        lag = 2'h0;
        bit_imm = 3'h0;
        op = zero_extend_op;
        size = size_long;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        t_logic();
        t_ext();
        t_shift();
        t_bit();
        t_mem();
        complete_run();
    end

    // About 120 cycles of work
    initial
    begin
        #20000;
        err_total++;
        complete_run();
    end
endmodule : cpu_logic_shift_bit_datapath_tb_top

`default_nettype wire

// ===== dv/mem_model.sv
`timescale 1ns/100ps
`default_nettype none

module mem_model
(
    input wire logic clk,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic [1:0] lag,
    output logic [7:0] mem_rdata,
    output logic mem_ack
);
    logic [7:0] mem [0:15];
    logic [1:0] wait_q;

    initial
    begin
        mem_ack = 1'b0;
        mem_rdata = 8'h00;
        wait_q = 2'h0;
        mem = '{default: 8'h00};
    end

    // Data toggles off the ack so stale data fails
    always @(posedge clk)
    begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack)
        begin
            if (wait_q < lag)
            begin
                wait_q <= wait_q + 2'h1;
            end
            else
            begin
                wait_q <= 2'h0;
                mem_ack <= 1'b1;
                if (mem_we)
                begin
                    mem[mem_addr[3:0]] <= mem_wdata;
                end
                else
                begin
                    mem_rdata <= mem[mem_addr[3:0]];
                end
            end
        end
    end
endmodule : mem_model

`default_nettype wire

// ===== hdl/cpu_logic_shift_bit_datapath.sv
// Behaviour
// - Zero extend byte to word, word to long
// - Sign extend by copying source top bit
// - Test memory byte, then set bit seven
// - AND destination with register or immediate
// - OR destination with register or immediate
// - XOR destination with register or immediate
// - NOT inverts every bit of operand
// - Arithmetic shifts by one or two
// - Logical shifts insert zeros, one or two
// - Rotates circulate bits, one or two
// - Rotates through carry include carry bit
// - Bit index from immediate or register
// - Bit set forces chosen bit high
// - Bit clear forces chosen bit low
// - Bit invert complements chosen bit
// - Carry becomes carry AND bit
// - Carry becomes carry AND inverted bit
// - Carry becomes carry OR bit
// - Carry becomes carry OR inverted bit
// - Inverted carry forms use immediate index
// - Size codes select 8, 16, 32
`timescale 1ns/100ps
`default_nettype none
`include "cpu_logic_params.svh"

module cpu_logic_shift_bit_datapath
    import cpu_logic_pkg::*;
#(
    parameter int unsigned ADDR_W = `ADDR_W
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire op_type op,
    input wire size_type size,
    input wire logic [31:0] dst_data,
    input wire logic [31:0] src_data,
    input wire logic [31:0] imm_data,
    input wire logic use_imm,
    input wire logic shift_two,
    input wire logic [2:0] bit_imm,
    input wire logic bit_from_reg,
    input wire logic [31:0] bit_reg,
    input wire logic mem_operand,
    input wire logic [ADDR_W-1:0] mem_addr_in,
    input wire logic carry_in,
    output logic ready,
    output logic done,
    output logic [31:0] result,
    output logic result_we,
    output logic flag_n,
    output logic flag_n_we,
    output logic flag_z,
    output logic flag_z_we,
    output logic flag_c,
    output logic flag_c_we,
    output logic mem_req,
    output logic mem_we,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack
);

    // --------------------
    // Request capture
    // --------------------
    state_type state_q;
    op_type op_q;
    logic [2:0] idx_q;
    logic carry_q;
    logic [ADDR_W-1:0] addr_q;

    logic accept;
    logic go_mem;
    logic [2:0] idx_sel;

    assign ready = (state_q == st_idle);
    assign accept = start && ready;
    // Test-and-set is always a memory op
    assign go_mem = (op == test_and_set_op)
        || (mem_operand && (op >= bit_set_op));

    // Inverted carry forms use the immediate index
    assign idx_sel = (bit_from_reg && (op != carry_and_inv_bit_op)
        && (op != carry_or_inv_bit_op)) ? bit_reg[2:0] : bit_imm;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            op_q <= zero_extend_op;
            idx_q <= 3'h0;
            carry_q <= 1'b0;
            addr_q <= '0;
        end
        else if (accept)
        begin
            op_q <= op;
            idx_q <= idx_sel;
            carry_q <= carry_in;
            addr_q <= mem_addr_in;
        end
    end

    // --------------------
    // Operand selection
    // --------------------
    // Memory ops compute on the read byte
    op_type cur_op;
    size_type cur_size;
    logic [31:0] cur_dst;
    logic [2:0] cur_idx;
    logic cur_c;
    logic [31:0] operand_b;

    always_comb
    begin
        if (state_q == st_read)
        begin
            cur_op = op_q;
            cur_size = size_byte;
            cur_dst = {24'h000000, mem_rdata};
            cur_idx = idx_q;
            cur_c = carry_q;
        end
        else
        begin
            cur_op = op;
            cur_size = size;
            cur_dst = dst_data;
            cur_idx = idx_sel;
            cur_c = carry_in;
        end
    end

    assign operand_b = use_imm ? imm_data : src_data;

    // --------------------
    // Shift and rotate unit
    // --------------------
    shift_if sh_if ();
    shift_kind_type kind;

    always_comb
    begin
        case (cur_op)
            arith_shift_left_op: kind = sk_asl;
            arith_shift_right_op: kind = sk_asr;
            logic_shift_left_op: kind = sk_lsl;
            logic_shift_right_op: kind = sk_lsr;
            rotate_left_op: kind = sk_rol;
            rotate_right_op: kind = sk_ror;
            rotate_carry_left_op: kind = sk_rcl;
            rotate_carry_right_op: kind = sk_rcr;
            default: kind = sk_lsl;
        endcase
    end

    assign sh_if.data = cur_dst;
    assign sh_if.size = cur_size;
    assign sh_if.kind = kind;
    assign sh_if.two = shift_two;
    assign sh_if.carry_in = cur_c;

    shift_rotate_unit u_shift
    (
        .sh(sh_if)
    );

    // --------------------
    // Result and flag computation
    // --------------------
    logic [31:0] mask;
    logic [4:0] msb;
    logic [31:0] val;
    logic [31:0] sized;
    logic [31:0] merged;
    logic [31:0] nz_src;
    logic [7:0] byte_mod;
    logic sel_bit;
    logic do_res_we;
    logic do_nz;
    logic do_z;
    logic do_c;
    logic z_bit;
    logic c_bit;
    logic need_write;

    // Extends take a byte code as word
    always_comb
    begin
        mask = `LONG_MASK;
        msb = `LONG_MSB;
        if ((cur_op == zero_extend_op) || (cur_op == sign_extend_op))
        begin
            if (cur_size != size_long)
            begin
                mask = `WORD_MASK;
                msb = `WORD_MSB;
            end
        end
        else if ((cur_op == test_and_set_op) || (cur_op >= bit_set_op) || (cur_size == size_byte))
        begin
            mask = `BYTE_MASK;
            msb = `BYTE_MSB;
        end
        else if (cur_size == size_word)
        begin
            mask = `WORD_MASK;
            msb = `WORD_MSB;
        end
    end

    always_comb
    begin
        val = cur_dst;
        byte_mod = cur_dst[7:0];
        sel_bit = cur_dst[cur_idx];
        do_res_we = 1'b0;
        do_nz = 1'b0;
        do_z = 1'b0;
        do_c = 1'b0;
        c_bit = cur_c;
        z_bit = 1'b0;
        need_write = 1'b0;
        case (cur_op)
            zero_extend_op:
            begin
                val = (cur_size == size_long) ? {16'h0000, cur_dst[15:0]}
                    : {24'h000000, cur_dst[7:0]};
                do_res_we = 1'b1;
                do_nz = 1'b1;
            end
            sign_extend_op:
            begin
                val = (cur_size == size_long) ? {{16{cur_dst[15]}}, cur_dst[15:0]}
                    : {{24{cur_dst[7]}}, cur_dst[7:0]};
                do_res_we = 1'b1;
                do_nz = 1'b1;
            end
            test_and_set_op:
            begin
                byte_mod[`TAS_BIT] = 1'b1;
                need_write = 1'b1;
                do_nz = 1'b1;
            end
            and_op, or_op, xor_op, not_op:
            begin
                case (cur_op)
                    and_op: val = cur_dst & operand_b;
                    or_op: val = cur_dst | operand_b;
                    xor_op: val = cur_dst ^ operand_b;
                    default: val = ~cur_dst;
                endcase
                do_res_we = 1'b1;
                do_nz = 1'b1;
            end
            bit_set_op, bit_clear_op, bit_invert_op:
            begin
                case (cur_op)
                    bit_set_op: byte_mod[cur_idx] = 1'b1;
                    bit_clear_op: byte_mod[cur_idx] = 1'b0;
                    default: byte_mod[cur_idx] = ~sel_bit;
                endcase
                val = {cur_dst[31:8], byte_mod};
                do_res_we = 1'b1;
                need_write = 1'b1;
            end
            bit_test_op:
            begin
                z_bit = ~sel_bit;
                do_z = 1'b1;
            end
            carry_and_bit_op:
            begin
                c_bit = cur_c & sel_bit;
                do_c = 1'b1;
            end
            carry_and_inv_bit_op:
            begin
                c_bit = cur_c & ~sel_bit;
                do_c = 1'b1;
            end
            carry_or_bit_op:
            begin
                c_bit = cur_c | sel_bit;
                do_c = 1'b1;
            end
            carry_or_inv_bit_op:
            begin
                c_bit = cur_c | ~sel_bit;
                do_c = 1'b1;
            end
            default:
            begin
                val = sh_if.result;
                c_bit = sh_if.carry_out;
                do_res_we = 1'b1;
                do_nz = 1'b1;
                do_c = 1'b1;
            end
        endcase
    end

    // Bits above the size keep old contents
    assign sized = val & mask;
    assign merged = (cur_dst & ~mask) | sized;
    // Test-and-set flags see the byte before the set
    assign nz_src = (cur_op == test_and_set_op) ? (cur_dst & mask) : sized;

    // --------------------
    // Sequencer
    // --------------------
    logic fire;
    logic finish_now;
    logic write_done;

    assign fire = (accept && !go_mem) || ((state_q == st_read) && mem_ack);
    assign finish_now = fire && !((state_q == st_read) && need_write);
    assign write_done = (state_q == st_write) && mem_ack;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= st_idle;
        end
        else
        begin
            case (state_q)
                st_idle:
                begin
                    if (accept && go_mem)
                    begin
                        state_q <= st_read;
                    end
                end
                st_read:
                begin
                    if (mem_ack)
                    begin
                        state_q <= need_write ? st_write : st_idle;
                    end
                end
                st_write:
                begin
                    if (mem_ack)
                    begin
                        state_q <= st_idle;
                    end
                end
                default:
                begin
                    state_q <= st_idle;
                end
            endcase
        end
    end

    // --------------------
    // Memory bus
    // --------------------
    // Request holds until acknowledged
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= `BYTE_RST;
        end
        else if (accept && go_mem)
        begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= mem_addr_in;
        end
        else if ((state_q == st_read) && mem_ack)
        begin
            mem_req <= need_write;
            mem_we <= need_write;
            mem_wdata <= byte_mod;
            mem_addr <= addr_q;
        end
        else if (write_done)
        begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
        end
    end

    // --------------------
    // Results and flags
    // --------------------
    logic pend_n_q;
    logic pend_z_q;
    logic pend_c_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            result <= `RESULT_RST;
            flag_n <= 1'b0;
            flag_z <= 1'b0;
            flag_c <= 1'b0;
            pend_n_q <= 1'b0;
            pend_z_q <= 1'b0;
            pend_c_q <= 1'b0;
        end
        else if (fire)
        begin
            result <= merged;
            flag_n <= do_z ? 1'b0 : nz_src[msb];
            flag_z <= do_z ? z_bit : (nz_src == 32'h0000_0000);
            flag_c <= c_bit;
            pend_n_q <= do_nz;
            pend_z_q <= do_nz || do_z;
            pend_c_q <= do_c;
        end
    end

    // Flag strobes pulse with done, after any write; result_we pulses only for register ops
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            done <= 1'b0;
            result_we <= 1'b0;
            flag_n_we <= 1'b0;
            flag_z_we <= 1'b0;
            flag_c_we <= 1'b0;
        end
        else
        begin
            done <= finish_now || write_done;
            result_we <= finish_now && do_res_we && (state_q == st_idle);
            flag_n_we <= (finish_now && do_nz) || (write_done && pend_n_q);
            flag_z_we <= (finish_now && (do_nz || do_z)) || (write_done && pend_z_q);
            flag_c_we <= (finish_now && do_c) || (write_done && pend_c_q);
        end
    end

endmodule : cpu_logic_shift_bit_datapath

`default_nettype wire

// ===== hdl/shift_rotate_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "cpu_logic_params.svh"

module shift_rotate_unit
    import cpu_logic_pkg::*;
(
    shift_if.unit sh
);

    // --------------------
    // One bit step within the selected width
    // --------------------
    // Bits above the width are masked, so right steps pull in nothing foreign
    function automatic logic [32:0] one_step(input logic [31:0] v, input logic [4:0] m,
                                             input logic [31:0] mask,
                                             input shift_kind_type k, input logic c);
        logic [31:0] r;
        logic co;
        logic top;
        r = v;
        co = c;
        top = v[m];
        case (k)
            sk_asl, sk_lsl:
            begin
                r = v << 1;
                co = top;
            end
            sk_asr:
            begin
                r = v >> 1;
                r[m] = top;
                co = v[0];
            end
            sk_lsr:
            begin
                r = v >> 1;
                co = v[0];
            end
            sk_rol:
            begin
                r = v << 1;
                r[0] = top;
                co = top;
            end
            sk_ror:
            begin
                r = v >> 1;
                r[m] = v[0];
                co = v[0];
            end
            sk_rcl:
            begin
                r = v << 1;
                r[0] = c;
                co = top;
            end
            sk_rcr:
            begin
                r = v >> 1;
                r[m] = c;
                co = v[0];
            end
            default:
            begin
                r = v;
            end
        endcase
        one_step = {co, r & mask};
    endfunction : one_step

    logic [31:0] mask;
    logic [4:0] msb;
    logic [32:0] first;
    logic [32:0] second;

    always_comb
    begin
        case (sh.size)
            size_byte:
            begin
                mask = `BYTE_MASK;
                msb = `BYTE_MSB;
            end
            size_word:
            begin
                mask = `WORD_MASK;
                msb = `WORD_MSB;
            end
            default:
            begin
                mask = `LONG_MASK;
                msb = `LONG_MSB;
            end
        endcase
    end

    // Two places is one step twice
    always_comb
    begin
        first = one_step(sh.data & mask, msb, mask, sh.kind, sh.carry_in);
        second = one_step(first[31:0], msb, mask, sh.kind, first[32]);
    end

    assign sh.result = sh.two ? second[31:0] : first[31:0];
    assign sh.carry_out = sh.two ? second[32] : first[32];

endmodule : shift_rotate_unit

`default_nettype wire
